/* include/rate_ctrl_pkg.sv */
// Constants, register map and state type for the decimating filter rate control.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz processing clock.
package rate_ctrl_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BLOCK_LEN = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_ERR_POP = 8'h18;
  localparam logic [7:0] OFF_SAMPLE_COUNT = 8'h1c;

  // Control register fields
  localparam int CTRL_BW_LSB = 0;
  localparam int CTRL_BW_W = 5;
  localparam int CTRL_HALVE_BIT = 8;
  localparam int CTRL_COMPLEX_BIT = 9;
  localparam int CTRL_WIDE_BIT = 10;
  localparam int CTRL_GAPLESS_BIT = 11;
  localparam int CTRL_TRAILER_BIT = 12;

  // Command register fields
  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_TRIGGER_BIT = 1;
  localparam int CMD_ABORT_BIT = 2;

  // Status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_BLOCK_OK_BIT = 2;
  localparam int STAT_GAPLESS_OK_BIT = 3;
  localparam int STAT_ERR_PEND_BIT = 8;
  localparam int STAT_ERR_LOST_BIT = 9;

  // Interrupt status and mask fields
  localparam int IRQ_BLOCK_DONE_BIT = 0;
  localparam int IRQ_OVERFLOW_BIT = 1;
  localparam int IRQ_SETUP_ERR_BIT = 2;
  localparam int IRQ_W = 3;

  // Error queue entry fields
  localparam int ERR_CODE_LSB = 0;
  localparam int ERR_SRC_LSB = 8;
  localparam int ERR_VALID_BIT = 31;
  localparam int ERR_DEPTH = 8;
  localparam int ERR_PTR_W = 3;

  localparam logic [7:0] ERR_BAD_BANDWIDTH = 8'h01;
  localparam logic [7:0] ERR_BAD_COMBINATION = 8'h02;
  localparam logic [7:0] ERR_OVERFLOW = 8'h03;
  localparam logic [7:0] SRC_CTRL_WRITE = 8'h01;
  localparam logic [7:0] SRC_ARM = 8'h02;
  localparam logic [7:0] SRC_ACQUISITION = 8'h03;

  // Limits and reset values
  localparam logic [4:0] BW_MAX = 5'h18;
  localparam logic [4:0] BW_RESET = 5'h00;
  localparam logic HALVE_RESET = 1'b0;
  localparam logic COMPLEX_RESET = 1'b0;
  localparam logic WIDE_RESET = 1'b1;
  localparam logic GAPLESS_RESET = 1'b0;
  localparam logic TRAILER_RESET = 1'b0;
  localparam logic [23:0] BLOCK_LEN_RESET = 24'h000400;
  localparam int BLOCK_LEN_W = 24;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_RUN,
    ST_TRAILER
  } acq_state_e;

endpackage : rate_ctrl_pkg

/* logic/octave_decimator.sv */
// Octave-stepped band limiting filter with output decimation.
// Assumes samples arrive as real/imaginary pairs with a valid strobe.
`timescale 1ns/10ps
module octave_decimator
  import rate_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restart,
  input wire logic [4:0] bandwidth_code,
  input wire logic halve,
  input wire logic in_valid,
  input wire logic signed [31:0] in_real,
  input wire logic signed [31:0] in_imag,
  output logic out_valid,
  output logic signed [31:0] out_real,
  output logic signed [31:0] out_imag
);

  logic signed [63:0] acc_r;
  logic signed [63:0] acc_i;
  logic signed [63:0] prev_r;
  logic signed [63:0] prev_i;
  logic signed [63:0] dump_r;
  logic signed [63:0] dump_i;
  logic signed [63:0] pair_r;
  logic signed [63:0] pair_i;
  logic [23:0] phase_cnt;
  logic [23:0] dump_mask;
  logic dump;
  logic filt_valid;
  logic keep_toggle;

  // Dump every 2^(n-1) inputs, so the output rate is fs/2^(n-1)
  assign dump_mask = (bandwidth_code == 5'h00) ? 24'h000000 :
                     24'((25'h1 << (bandwidth_code - 5'h01)) - 25'h1);
  assign dump = in_valid && ((phase_cnt & dump_mask) == dump_mask);
  assign dump_r = acc_r + 64'(in_real);
  assign dump_i = acc_i + 64'(in_imag);
  // Two adjacent dumps form a 2^n wide boxcar, band edge near fs/2^n
  assign pair_r = (prev_r + dump_r) >>> bandwidth_code;
  assign pair_i = (prev_i + dump_i) >>> bandwidth_code;
  assign filt_valid = (bandwidth_code == 5'h00) ? in_valid : dump;

  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      phase_cnt <= 24'h000000;
      acc_r <= 64'h0;
      acc_i <= 64'h0;
      prev_r <= 64'h0;
      prev_i <= 64'h0;
    end else if (in_valid) begin
      phase_cnt <= phase_cnt + 24'h000001;
      if (dump) begin
        acc_r <= 64'h0;
        acc_i <= 64'h0;
        prev_r <= dump_r;
        prev_i <= dump_i;
      end else begin
        acc_r <= dump_r;
        acc_i <= dump_i;
      end
    end
  end

  // Extra halving drops every second filtered sample
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      keep_toggle <= 1'b0;
      out_valid <= 1'b0;
      out_real <= 32'h00000000;
      out_imag <= 32'h00000000;
    end else begin
      out_valid <= 1'b0;
      if (filt_valid) begin
        keep_toggle <= halve ? !keep_toggle : 1'b0;
        out_valid <= !(halve && keep_toggle);
        if (bandwidth_code == 5'h00) begin
          out_real <= in_real;
          out_imag <= in_imag;
        end else begin
          out_real <= pair_r[31:0];
          out_imag <= pair_i[31:0];
        end
      end
    end
  end

endmodule : octave_decimator

/* logic/rate_ctrl.sv */
// Decimating filter rate control: register file, acquisition sequencing,
// legality checks, error queue and memory word writer.
// Assumes mixed baseband samples in, a memory write port with ready, one clock.
`timescale 1ns/10ps
module rate_ctrl
  import rate_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trigger_in,
  input wire logic adc_overload,
  input wire logic adc_error,
  input wire logic sample_valid,
  input wire logic [31:0] sample_real,
  input wire logic [31:0] sample_imag,
  output logic mem_wr_valid,
  output logic [31:0] mem_wr_data,
  input wire logic mem_wr_ready,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Bit 1 allows block, bit 0 allows gapless
  function automatic logic [1:0] mode_allowed(input logic [4:0] code,
                                              input logic halve_in,
                                              input logic cplx,
                                              input logic wide);
    logic low_bw;
    logic [1:0] res;
    low_bw = (code <= 5'h01);
    res = 2'b11;
    if (!halve_in && low_bw) begin
      if (cplx && wide) begin
        res = 2'b00;
      end else if (cplx || wide) begin
        res = 2'b10;
      end
    end else if (cplx && wide && ((halve_in && low_bw) || (!halve_in && code == 5'h02))) begin
      res = 2'b10;
    end
    return res;
  endfunction : mode_allowed

  ////////////////////////////////////////////////////////////////////////////
  // Settings and state

  logic [4:0] bandwidth_code;
  logic halve;
  logic sample_kind;
  logic wide;
  logic gapless_acquisition;
  logic trailer_status_enable;
  logic [23:0] block_len;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  acq_state_e state;
  logic [23:0] sample_count;
  logic [1:0] allowed;
  logic [31:0] ctrl_word;

  assign allowed = mode_allowed(bandwidth_code, halve, sample_kind, wide);
  assign ctrl_word = {19'h0, trailer_status_enable, gapless_acquisition, wide,
                      sample_kind, halve, 3'h0, bandwidth_code};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] wr_ctrl;
  logic wr_mapped;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl = merge_bytes(ctrl_word, w_data, w_strb);
  assign wr_mapped = (aw_addr == OFF_CTRL) || (aw_addr == OFF_CMD) ||
                     (aw_addr == OFF_BLOCK_LEN) || (aw_addr == OFF_IRQ_STATUS) ||
                     (aw_addr == OFF_IRQ_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Write decodes
  logic ctrl_wr;
  logic ctrl_bad;
  logic ctrl_changed;
  logic cmd_wr;
  logic arm_req;
  logic arm_legal;
  logic trig_req;
  logic abort_req;
  logic [31:0] len_merged;
  logic [23:0] len_next;
  logic len_changed;

  assign ctrl_wr = do_write && aw_addr == OFF_CTRL;
  assign ctrl_bad = ctrl_wr && (wr_ctrl[CTRL_BW_LSB +: CTRL_BW_W] > BW_MAX);
  assign ctrl_changed = ctrl_wr && !ctrl_bad && (wr_ctrl != ctrl_word);
  assign cmd_wr = do_write && aw_addr == OFF_CMD;
  assign arm_req = cmd_wr && w_strb[0] && w_data[CMD_ARM_BIT];
  assign trig_req = (cmd_wr && w_strb[0] && w_data[CMD_TRIGGER_BIT]) || trigger_in;
  assign abort_req = cmd_wr && w_strb[0] && w_data[CMD_ABORT_BIT];
  assign arm_legal = gapless_acquisition ? allowed[0] : allowed[1];
  assign len_merged = merge_bytes({8'h00, block_len}, w_data, w_strb);
  assign len_next = (len_merged[23:0] == 24'h000000) ? 24'h000001 : len_merged[23:0];
  assign len_changed = do_write && aw_addr == OFF_BLOCK_LEN && (len_next != block_len);

  // Rejected codes leave every setting untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bandwidth_code <= BW_RESET;
      halve <= HALVE_RESET;
      sample_kind <= COMPLEX_RESET;
      wide <= WIDE_RESET;
      gapless_acquisition <= GAPLESS_RESET;
      trailer_status_enable <= TRAILER_RESET;
    end else if (ctrl_wr && !ctrl_bad) begin
      bandwidth_code <= wr_ctrl[CTRL_BW_LSB +: CTRL_BW_W];
      halve <= wr_ctrl[CTRL_HALVE_BIT];
      sample_kind <= wr_ctrl[CTRL_COMPLEX_BIT];
      wide <= wr_ctrl[CTRL_WIDE_BIT];
      gapless_acquisition <= wr_ctrl[CTRL_GAPLESS_BIT];
      trailer_status_enable <= wr_ctrl[CTRL_TRAILER_BIT];
    end
  end

  // Zero length would never end a block, so it is held at one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_len <= BLOCK_LEN_RESET;
      irq_mask <= '0;
    end else if (do_write) begin
      if (aw_addr == OFF_BLOCK_LEN) begin
        block_len <= len_next;
      end
      if (aw_addr == OFF_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filter and memory writer

  logic restart;
  logic f_valid;
  logic [31:0] f_real;
  logic [31:0] f_imag;
  logic second_pending;
  logic [31:0] second_word;
  logic slot_free;
  logic take;
  logic overflow_ev;
  logic block_end;
  logic trailer_go;
  logic ovl_seen;
  logic err_seen;

  assign restart = (state == ST_ARMED) && trig_req;

  // Centre shift is done by the mixer ahead, so this low pass lands on it
  octave_decimator u_decim (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(restart),
    .bandwidth_code(bandwidth_code),
    .halve(halve),
    .in_valid(sample_valid),
    .in_real(sample_real),
    .in_imag(sample_imag),
    .out_valid(f_valid),
    .out_real(f_real),
    .out_imag(f_imag)
  );

  assign slot_free = !mem_wr_valid || (mem_wr_ready && !second_pending);
  assign take = (state == ST_RUN) && f_valid && slot_free;
  assign overflow_ev = (state == ST_RUN) && f_valid && !slot_free;
  assign block_end = take && (sample_count + 24'h000001 == block_len);
  assign trailer_go = (state == ST_TRAILER) && slot_free;

  // One word per clock; the imaginary half of a wide complex sample waits until the real half is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_wr_valid <= 1'b0;
      mem_wr_data <= 32'h00000000;
      second_pending <= 1'b0;
      second_word <= 32'h00000000;
    end else if (take) begin
      mem_wr_valid <= 1'b1;
      second_pending <= sample_kind && wide;
      second_word <= f_imag;
      if (wide) begin
        mem_wr_data <= f_real;
      end else if (sample_kind) begin
        mem_wr_data <= {f_real[31:16], f_imag[31:16]};
      end else begin
        mem_wr_data <= {16'h0000, f_real[31:16]};
      end
    end else if (trailer_go) begin
      mem_wr_valid <= 1'b1;
      mem_wr_data <= {30'h0, err_seen, ovl_seen};
    end else if (mem_wr_valid && mem_wr_ready) begin
      mem_wr_valid <= second_pending;
      mem_wr_data <= second_word;
      second_pending <= 1'b0;
    end
  end

  // Per-block ADC flags for the trailer word
  always_ff @(posedge aclk) begin
    if (!aresetn || restart || trailer_go) begin
      ovl_seen <= 1'b0;
      err_seen <= 1'b0;
    end else if (state == ST_RUN) begin
      ovl_seen <= ovl_seen || adc_overload;
      err_seen <= err_seen || adc_error;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition sequencing

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
    end else if (abort_req || ctrl_changed || len_changed) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (arm_req && arm_legal) begin
            state <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (trig_req) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (overflow_ev) begin
            state <= ST_IDLE;
          end else if (block_end && !gapless_acquisition) begin
            state <= trailer_status_enable ? ST_TRAILER : ST_IDLE;
          end
        end
        ST_TRAILER: begin
          if (trailer_go) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Gapless wraps the count and keeps running
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      sample_count <= 24'h000000;
    end else if (take) begin
      sample_count <= block_end ? 24'h000000 : sample_count + 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error queue

  logic [15:0] err_mem [ERR_DEPTH];
  logic [ERR_PTR_W-1:0] err_head;
  logic [ERR_PTR_W-1:0] err_tail;
  logic [ERR_PTR_W:0] err_count;
  logic err_lost;
  logic push;
  logic [15:0] push_entry;
  logic pop;
  logic arm_reject;

  assign arm_reject = arm_req && (state == ST_IDLE) && !arm_legal;
  assign push = ctrl_bad || arm_reject || overflow_ev;
  // Only one write per cycle, so setup errors never collide with each other
  assign push_entry = ctrl_bad ? {SRC_CTRL_WRITE, ERR_BAD_BANDWIDTH} :
                      arm_reject ? {SRC_ARM, ERR_BAD_COMBINATION} :
                      {SRC_ACQUISITION, ERR_OVERFLOW};
  assign pop = s_axi_arvalid && s_axi_arready && ({s_axi_araddr[7:2], 2'b00} == OFF_ERR_POP) &&
               (err_count != '0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_head <= '0;
      err_tail <= '0;
      err_count <= '0;
      err_lost <= 1'b0;
    end else begin
      if (push && (err_count < 4'(ERR_DEPTH) || pop)) begin
        err_mem[err_tail] <= push_entry;
        err_tail <= err_tail + 1'b1;
      end else if (push) begin
        err_lost <= 1'b1;
      end
      if (pop) begin
        err_head <= err_head + 1'b1;
      end
      if (push && (err_count < 4'(ERR_DEPTH) || pop) && !pop) begin
        err_count <= err_count + 1'b1;
      end else if (pop && !push) begin
        err_count <= err_count - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_set = {ctrl_bad || arm_reject, overflow_ev, take && sample_count + 24'h1 == block_len};
  assign irq_clr = (do_write && aw_addr == OFF_IRQ_STATUS && w_strb[0]) ?
                   w_data[IRQ_W-1:0] : '0;

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path; reads never disturb acquisition

  logic [7:0] rd_addr;
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (rd_addr)
        OFF_CTRL: s_axi_rdata <= ctrl_word;
        OFF_CMD: s_axi_rdata <= 32'h00000000;
        OFF_STATUS: s_axi_rdata <= {22'h0, err_lost, err_count != '0, 4'h0,
                                    allowed[0], allowed[1], 2'(state)};
        OFF_BLOCK_LEN: s_axi_rdata <= {8'h00, block_len};
        OFF_IRQ_STATUS: s_axi_rdata <= {29'h0, irq_status};
        OFF_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
        OFF_ERR_POP: s_axi_rdata <= (err_count != '0) ?
                                    {1'b1, 15'h0, err_mem[err_head]} : 32'h0;
        OFF_SAMPLE_COUNT: s_axi_rdata <= {8'h00, sample_count};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : rate_ctrl

/* dv/rate_ctrl_asserts.sv */
// Port timing checks for rate_ctrl.
// Bound to rate_ctrl from tb_top; one clock domain.
`timescale 1ns/10ps
module rate_ctrl_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mem_wr_valid,
  input wire logic [31:0] mem_wr_data,
  input wire logic mem_wr_ready,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property (
    $rose(aresetn) |-> !mem_wr_valid && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("output active after reset");
  a_mem_hold: assert property (
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_data))
    else $error("memory word dropped while stalled");
  a_rd_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_busy: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_wr_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule : rate_ctrl_asserts

/* dv/mem_sink.sv */
// Reader draining the memory word port.
// Stalls three cycles of four when slow is high.
`timescale 1ns/10ps
module mem_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic mem_wr_valid,
  input wire logic [31:0] mem_wr_data,
  output logic mem_wr_ready,
  output logic [31:0] last_word,
  output int count
);
  logic [1:0] phase;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 2'h0;
      count <= 0;
      last_word <= 32'h0;
    end else begin
      phase <= phase + 2'h1;
      if (mem_wr_valid && mem_wr_ready) begin
        count <= count + 1;
        last_word <= mem_wr_data;
      end
    end
  end
  // Slow draining still keeps up with the sample spacing
  assign mem_wr_ready = !slow || phase == 2'h3;
endmodule : mem_sink

/* dv/tb_top.sv */
// Self-checking bench for rate_ctrl.
// Drives AXI4-Lite, samples and trigger; mem_sink drains words.
`timescale 1ns/10ps
module tb_top import rate_ctrl_pkg::*;;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, trigger_in = 0, adc_overload = 0;
  logic adc_error = 0, sample_valid = 0, slow = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, sample_real = 0, sample_imag = 0;
  logic [31:0] s_axi_rdata, mem_wr_data, last_word, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mem_wr_valid, mem_wr_ready, irq;
  int count, fail_count = 0, check_count = 0;
  rate_ctrl dut (.*);
  mem_sink sink (.*);
  always #5 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      ad = ad || s_axi_awready;
      dd = dd || s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !dd;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
    chk("register", e, rd & m);
  endtask : rc
  // Arms, triggers, feeds n spaced samples, counts words
  task automatic run(input logic [31:0] ctl, input logic [31:0] len, input int n,
                     input int words);
    int c0;
    wr(OFF_CTRL, ctl);
    wr(OFF_BLOCK_LEN, len);
    wr(OFF_CMD, 32'h1);
    trigger_in <= 1;
    @(posedge aclk);
    trigger_in <= 0;
    c0 = count;
    for (int i = 0; i < n; i++) begin
      sample_valid <= 1;
      sample_real <= 32'h12340000 + i;
      sample_imag <= 32'h56780000 - i;
      @(posedge aclk);
      sample_valid <= 0;
      repeat (7) @(posedge aclk);
    end
    repeat (10) @(posedge aclk);
    chk("words", words, count - c0);
  endtask : run
  task automatic wrap_up;
    if (fail_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  task automatic s_reset;
    rc(OFF_CTRL, 32'hffffffff, 32'h400);
    rc(OFF_BLOCK_LEN, 32'hffffffff, 32'h400);
    rc(8'h40, 32'hffffffff, 32'h0);
    chk("rresp", RESP_SLVERR, rr);
  endtask : s_reset
  task automatic s_legal;
    logic [31:0] ctl [7] = '{32'h200, 32'h401, 32'h601, 32'h701, 32'h602, 32'h603, 32'h0};
    logic [31:0] ok [7] = '{32'h4, 32'h4, 32'h0, 32'h4, 32'h4, 32'hc, 32'hc};
    for (int i = 0; i < 7; i++) begin
      wr(OFF_CTRL, ctl[i]);
      rc(OFF_STATUS, 32'hc, ok[i]);
    end
    wr(OFF_CTRL, 32'h19);
    rc(OFF_CTRL, 32'hffffffff, 32'h0);
    wr(OFF_CTRL, 32'h18);
    rc(OFF_CTRL, 32'hffffffff, 32'h18);
    wr(OFF_CTRL, 32'h601);
    wr(OFF_CMD, 32'h1);
    rc(OFF_STATUS, 32'h3, 32'h0);
    rc(OFF_ERR_POP, 32'hffffffff, 32'h80000101);
    rc(OFF_ERR_POP, 32'hffffffff, 32'h80000202);
    rc(OFF_ERR_POP, 32'h80000000, 32'h0);
    rc(OFF_IRQ_STATUS, 32'h4, 32'h4);
    chk("irq", 32'h0, irq);
    wr(OFF_IRQ_MASK, 32'h4);
    chk("irq", 32'h1, irq);
    wr(OFF_IRQ_STATUS, 32'h4);
    chk("irq", 32'h0, irq);
  endtask : s_legal
  task automatic s_stream;
    run(32'h400, 32'h4, 6, 4);
    chk("word", 32'h12340003, last_word);
    rc(OFF_STATUS, 32'h3, 32'h0);
    run(32'h402, 32'h100, 8, 4);
    rc(OFF_CTRL, 32'hffffffff, 32'h402);
    rc(OFF_STATUS, 32'h3, 32'h2);
    wr(OFF_CTRL, 32'h403);
    rc(OFF_STATUS, 32'h3, 32'h0);
    run(32'h502, 32'h100, 8, 2);
    wr(OFF_CMD, 32'h4);
    rc(OFF_STATUS, 32'h3, 32'h0);
  endtask : s_stream
  task automatic s_gapless;
    wr(OFF_IRQ_STATUS, 32'h7);
    adc_overload <= 1;
    run(32'h1400, 32'h2, 3, 3);
    adc_overload <= 0;
    chk("word", 32'h1, last_word);
    rc(OFF_IRQ_STATUS, 32'h1, 32'h1);
    run(32'h800, 32'h2, 6, 6);
    chk("word", 32'h1234, last_word);
    rc(OFF_STATUS, 32'h3, 32'h2);
    sample_valid <= 1;
    repeat (4) @(posedge aclk);
    sample_valid <= 0;
    repeat (4) @(posedge aclk);
    rc(OFF_STATUS, 32'h3, 32'h0);
    rc(OFF_ERR_POP, 32'hffffffff, 32'h80000303);
    rc(OFF_IRQ_STATUS, 32'h2, 32'h2);
  endtask : s_gapless
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    s_reset();
    s_legal();
    s_stream();
    s_gapless();
    wrap_up();
  end
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    wrap_up();
  end
endmodule : tb_top
bind rate_ctrl rate_ctrl_asserts sva (.*);
